// *** core/egress_tag_pkg.sv ***
// Purpose: shared types and constants for the egress tag lookup stage
// Assumes: one switch core clock, twelve egress ports
// Notes:   packed struct layouts below are the key and action bit positions, lsb last

package egress_tag_pkg;

  localparam int          ENTRY_COUNT    = 256;
  localparam int          IDX_W          = 8;
  localparam int          PORT_COUNT     = 12;
  localparam int          PORT_W         = 4;
  localparam int          KEY_W          = 28;
  localparam int          ACTION_W       = 74;
  localparam int          MCAST_BIT      = 40;
  localparam int          LOOKUP_LATENCY = 3;
  localparam logic [15:0] TPID_CTAG      = 16'h8100;
  localparam logic [15:0] TPID_STAG      = 16'h88A8;
  localparam logic [47:0] BCAST_ADDR     = 48'hFFFF_FFFF_FFFF;

  typedef enum logic [1:0] {
    OUTER_PORT_ALLOWED,
    OUTER_FIRST_TAG,
    OUTER_FORCE_PORT,
    OUTER_FORCE_UNTAG
  } outer_ctl_t;

  typedef enum logic [1:0] {
    ETYPE_CTAG,
    ETYPE_STAG,
    ETYPE_CUSTOM,
    ETYPE_BY_KIND
  } ethertype_sel_t;

  typedef enum logic [1:0] {
    PRI_CLASSIFIED,
    PRI_VALUE,
    PRI_MAPPED,
    PRI_QOS
  } priority_sel_t;

  typedef enum logic [1:0] {
    ELI_CLASSIFIED,
    ELI_VALUE,
    ELI_MAPPED,
    ELI_DROP
  } eligible_sel_t;

  // key bit 0 is tx port lsb, bit 27 is pcp msb
  typedef struct packed {
    logic [2:0]  pcp;
    logic        drop_precedence;
    logic [11:0] vid;
    logic        dest_broadcast_flag;
    logic        dest_multicast_flag;
    logic [1:0]  reserved;
    logic [3:0]  receive_port_number;
    logic [3:0]  transmit_port_number;
  } lookup_key_t;

  typedef struct packed {
    eligible_sel_t  eligible_select;
    priority_sel_t  priority_select;
    logic           vlan_select;
    ethertype_sel_t ethertype_select;
  } tag_select_t;

  // action bit 0 is outer control lsb, bit 73 is the sticky hit
  typedef struct packed {
    logic        hit;
    logic [23:0] reserved;
    logic        second_tag_eligible_value;
    logic [2:0]  second_tag_priority_value;
    logic [11:0] second_tag_vlan_value;
    logic        first_tag_eligible_value;
    logic [2:0]  first_tag_priority_value;
    logic [11:0] first_tag_vlan_value;
    tag_select_t second_sel;
    tag_select_t first_sel;
    logic        push_inner;
    outer_ctl_t  push_outer;
  } action_t;

  typedef struct packed {
    logic [11:0] vid;
    logic [2:0]  pcp;
    logic        dei;
    logic        drop_precedence;
    logic [2:0]  qos_class;
    logic        internal_header_tag_kind;
    logic [15:0] port_custom_ethertype;
    logic [2:0]  mapped_pcp;
    logic        mapped_dei;
  } frame_ctx_t;

  typedef struct packed {
    logic        push;
    logic [15:0] tpid;
    logic [11:0] vid;
    logic [2:0]  pcp;
    logic        dei;
  } tag_out_t;

  localparam action_t     ACTION_RESET = '0;
  localparam frame_ctx_t  CTX_RESET    = '0;
  localparam lookup_key_t KEY_RESET    = '0;
  localparam tag_out_t    TAG_RESET    = '0;

endpackage

// *** core/lookup_key_builder.sv ***
// Purpose: forms the 28-bit lookup key for one destination port of a frame
// Assumes: inputs are from the classification pipeline on the same clock
// Notes:   purely combinational

`timescale 1ns/10ps

module lookup_key_builder
  import egress_tag_pkg::*;
(
  input  wire logic [3:0]  transmit_port_number_i,
  input  wire logic [3:0]  receive_port_number_i,
  input  wire logic [47:0] dest_mac_i,
  input  wire logic [11:0] vid_i,
  input  wire logic        drop_precedence_i,
  input  wire logic [2:0]  pcp_i,
  output lookup_key_t      key_o
);

  always_comb begin
    key_o                      = KEY_RESET;
    key_o.transmit_port_number = transmit_port_number_i;
    key_o.receive_port_number  = receive_port_number_i;
    key_o.dest_multicast_flag  = dest_mac_i[MCAST_BIT];
    key_o.dest_broadcast_flag  = (dest_mac_i == BCAST_ADDR);
    key_o.vid                  = vid_i;
    key_o.drop_precedence      = drop_precedence_i;
    key_o.pcp                  = pcp_i;
  end

endmodule

// *** core/tag_field_resolver.sv ***
// Purpose: turns one tag's selectors and literal values into the tag to push
// Assumes: frame context already registered by the caller
// Notes:   used for both the outer and inner tag, same encodings

`timescale 1ns/10ps

module tag_field_resolver
  import egress_tag_pkg::*;
(
  input  wire logic        push_i,
  input  tag_select_t      sel_i,
  input  wire logic [11:0] vlan_value_i,
  input  wire logic [2:0]  priority_value_i,
  input  wire logic        eligible_value_i,
  input  frame_ctx_t       ctx_i,
  output tag_out_t         tag_o
);

  always_comb begin
    tag_o      = TAG_RESET;
    tag_o.push = push_i;
    unique case (sel_i.ethertype_select)
      ETYPE_CTAG:    tag_o.tpid = TPID_CTAG;
      ETYPE_STAG:    tag_o.tpid = TPID_STAG;
      ETYPE_CUSTOM:  tag_o.tpid = ctx_i.port_custom_ethertype;
      ETYPE_BY_KIND: begin
        tag_o.tpid = ctx_i.internal_header_tag_kind ? ctx_i.port_custom_ethertype
                                                    : TPID_CTAG;
      end
    endcase
    // vid sum wraps modulo 4096, as a 12-bit field must
    tag_o.vid = sel_i.vlan_select ? vlan_value_i
                                  : 12'(ctx_i.vid + vlan_value_i);
    unique case (sel_i.priority_select)
      PRI_CLASSIFIED: tag_o.pcp = ctx_i.pcp;
      PRI_VALUE:      tag_o.pcp = priority_value_i;
      PRI_MAPPED:     tag_o.pcp = ctx_i.mapped_pcp;
      PRI_QOS:        tag_o.pcp = ctx_i.qos_class;
    endcase
    unique case (sel_i.eligible_select)
      ELI_CLASSIFIED: tag_o.dei = ctx_i.dei;
      ELI_VALUE:      tag_o.dei = eligible_value_i;
      ELI_MAPPED:     tag_o.dei = ctx_i.mapped_dei;
      ELI_DROP:       tag_o.dei = ctx_i.drop_precedence;
    endcase
  end

endmodule

// *** core/egress_tag_rule_lookup.sv ***
// Purpose: egress tag lookup, key match over 256 entries and tag action decode
// Assumes: one lookup request per destination port, at most one per clock
// Notes:   table is written and read through plain ports, latency is three clocks
//
// Function
// - one lookup per destination port, key from classification
// - table holds 256 match entries
// - key bits 3:0 carry transmit port
// - key bits 7:4 carry receive port
// - key bit 10 set for multicast destination
// - key bit 11 set for broadcast destination
// - key bits 23:12 carry classified VLAN ID
// - key bit 24 carries post-policing drop precedence
// - key bits 27:25 carry classified priority
// - no match returns per-port default action
// - outer control selects port tag or first tag
// - action bit 2 pushes second tag inner
// - ethertype selector picks 8100, 88A8 or custom
// - vlan selector adds or replaces classified VID
// - priority selector picks classified, value, mapped, qos
// - eligible selector picks classified, value, mapped, drop
// - first tag values at bits 17, 29, 32
// - second tag values at bits 33, 45, 48
// - matched entry sets its sticky hit bit

`timescale 1ns/10ps

module egress_tag_rule_lookup
  import egress_tag_pkg::*;
(
  input  wire logic                      mclk_i,
  input  wire logic                      rstn_i,
  // lookup request
  input  wire logic                      req_valid_i,
  input  wire logic [3:0]                transmit_port_number_i,
  input  wire logic [3:0]                receive_port_number_i,
  input  wire logic [47:0]               dest_mac_i,
  input  egress_tag_pkg::frame_ctx_t     req_ctx_i,
  // lookup result
  output logic                           result_valid_o,
  output egress_tag_pkg::outer_ctl_t     outer_ctl_o,
  output egress_tag_pkg::tag_out_t       first_tag_o,
  output egress_tag_pkg::tag_out_t       second_tag_o,
  output logic                           matched_o,
  output logic [egress_tag_pkg::IDX_W-1:0] match_index_o,
  // entry programming
  input  wire logic                      entry_write_i,
  input  wire logic [egress_tag_pkg::IDX_W-1:0] entry_index_i,
  input  wire logic                      entry_enable_i,
  input  egress_tag_pkg::lookup_key_t    entry_key_i,
  input  egress_tag_pkg::lookup_key_t    entry_mask_i,
  input  egress_tag_pkg::action_t        entry_action_i,
  input  wire logic                      default_write_i,
  input  wire logic [3:0]                default_port_i,
  input  egress_tag_pkg::action_t        default_action_i,
  input  wire logic                      hit_clear_i,
  input  wire logic [egress_tag_pkg::IDX_W-1:0] hit_clear_index_i,
  // entry readback
  input  wire logic                      entry_read_i,
  input  wire logic [egress_tag_pkg::IDX_W-1:0] read_index_i,
  output logic                           read_valid_o,
  output logic                           read_enable_o,
  output egress_tag_pkg::lookup_key_t    read_key_o,
  output egress_tag_pkg::lookup_key_t    read_mask_o,
  output egress_tag_pkg::action_t        read_action_o
);

  import egress_tag_pkg::*;

  typedef struct packed {
    logic [ENTRY_COUNT-1:0] entry_enable;
    logic [ENTRY_COUNT-1:0] sticky;
    logic                   s1_valid;
    lookup_key_t            s1_key;
    frame_ctx_t             s1_ctx;
    logic                   s2_valid;
    logic                   s2_hit;
    logic [IDX_W-1:0]       s2_index;
    action_t                s2_action;
    frame_ctx_t             s2_ctx;
    logic                   out_valid;
    outer_ctl_t             out_outer;
    tag_out_t               out_first;
    tag_out_t               out_second;
    logic                   out_hit;
    logic [IDX_W-1:0]       out_index;
    logic                   rd_valid;
    logic                   rd_enable;
    lookup_key_t            rd_key;
    lookup_key_t            rd_mask;
    action_t                rd_action;
  } state_t;

  localparam state_t STATE_RESET = '0;

  state_t st_reg;
  state_t st_next;

  // table storage: match arrays carry no reset, the enable vector gates them; default_mem resets to ACTION_RESET
  lookup_key_t key_mem     [ENTRY_COUNT];
  lookup_key_t mask_mem    [ENTRY_COUNT];
  action_t     action_mem  [ENTRY_COUNT];
  action_t     default_mem [PORT_COUNT];

  lookup_key_t            req_key;
  logic [ENTRY_COUNT-1:0] match_vec;
  logic                   any_match;
  logic [IDX_W-1:0]       first_index;
  action_t                default_sel;
  tag_out_t               first_tag;
  tag_out_t               second_tag;

  function automatic logic [IDX_W-1:0] lowest_set(input logic [ENTRY_COUNT-1:0] vec);
    logic [IDX_W-1:0] idx;
    idx = '0;
    for (int i = ENTRY_COUNT - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = IDX_W'(i);
      end
    end
    return idx;
  endfunction

  lookup_key_builder u_key (
    .transmit_port_number_i (transmit_port_number_i),
    .receive_port_number_i  (receive_port_number_i),
    .dest_mac_i             (dest_mac_i),
    .vid_i                  (req_ctx_i.vid),
    .drop_precedence_i      (req_ctx_i.drop_precedence),
    .pcp_i                  (req_ctx_i.pcp),
    .key_o                  (req_key)
  );

  // mask bit high means compare; reserved key bits are expected masked by software
  for (genvar g = 0; g < ENTRY_COUNT; g++) begin : g_match
    assign match_vec[g] = st_reg.entry_enable[g] &&
                          (((st_reg.s1_key ^ key_mem[g]) & mask_mem[g]) == KEY_RESET);
  end

  assign any_match   = |match_vec;
  assign first_index = lowest_set(match_vec);

  // ports past the last one have no default and fall back to an inert action
  assign default_sel = (st_reg.s1_key.transmit_port_number < PORT_W'(PORT_COUNT))
                     ? default_mem[st_reg.s1_key.transmit_port_number]
                     : ACTION_RESET;

  tag_field_resolver u_first (
    .push_i           (st_reg.s2_action.push_outer == OUTER_FIRST_TAG),
    .sel_i            (st_reg.s2_action.first_sel),
    .vlan_value_i     (st_reg.s2_action.first_tag_vlan_value),
    .priority_value_i (st_reg.s2_action.first_tag_priority_value),
    .eligible_value_i (st_reg.s2_action.first_tag_eligible_value),
    .ctx_i            (st_reg.s2_ctx),
    .tag_o            (first_tag)
  );

  tag_field_resolver u_second (
    .push_i           (st_reg.s2_action.push_inner),
    .sel_i            (st_reg.s2_action.second_sel),
    .vlan_value_i     (st_reg.s2_action.second_tag_vlan_value),
    .priority_value_i (st_reg.s2_action.second_tag_priority_value),
    .eligible_value_i (st_reg.s2_action.second_tag_eligible_value),
    .ctx_i            (st_reg.s2_ctx),
    .tag_o            (second_tag)
  );

  always_ff @(posedge mclk_i) begin
    if (entry_write_i) begin
      key_mem[entry_index_i]    <= entry_key_i;
      mask_mem[entry_index_i]   <= entry_mask_i;
      action_mem[entry_index_i] <= entry_action_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int p = 0; p < PORT_COUNT; p++) begin
        default_mem[p] <= ACTION_RESET;
      end
    end else if (default_write_i && (default_port_i < PORT_W'(PORT_COUNT))) begin
      default_mem[default_port_i] <= default_action_i;
    end
  end

  always_comb begin
    st_next = st_reg;

    // stage 1: capture one key per destination port request
    st_next.s1_valid = req_valid_i;
    st_next.s1_key   = req_key;
    st_next.s1_ctx   = req_ctx_i;

    // stage 2: match and action fetch
    st_next.s2_valid = st_reg.s1_valid;
    st_next.s2_ctx   = st_reg.s1_ctx;
    st_next.s2_hit   = any_match;
    st_next.s2_index = first_index;
    st_next.s2_action = any_match ? action_mem[first_index] : default_sel;
    st_next.s2_action.hit = any_match;

    // stage 3: registered result, held between pulses so a late sampler sees the last one
    st_next.out_valid  = st_reg.s2_valid;
    if (st_reg.s2_valid) begin
      st_next.out_outer  = st_reg.s2_action.push_outer;
      st_next.out_first  = first_tag;
      st_next.out_second = second_tag;
      st_next.out_hit    = st_reg.s2_hit;
      st_next.out_index  = st_reg.s2_index;
    end

    // table programming, sticky clear before set so a hit in the clear cycle survives
    if (entry_write_i) begin
      st_next.entry_enable[entry_index_i] = entry_enable_i;
      st_next.sticky[entry_index_i]       = entry_action_i.hit;
    end
    if (hit_clear_i) begin
      st_next.sticky[hit_clear_index_i] = 1'b0;
    end
    if (st_reg.s1_valid && any_match) begin
      st_next.sticky[first_index] = 1'b1;
    end

    // readback shows the live sticky bit in the hit position
    st_next.rd_valid = entry_read_i;
    if (entry_read_i) begin
      st_next.rd_enable     = st_reg.entry_enable[read_index_i];
      st_next.rd_key        = key_mem[read_index_i];
      st_next.rd_mask       = mask_mem[read_index_i];
      st_next.rd_action     = action_mem[read_index_i];
      st_next.rd_action.hit = st_reg.sticky[read_index_i];
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_reg <= STATE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign result_valid_o = st_reg.out_valid;
  assign outer_ctl_o    = st_reg.out_outer;
  assign first_tag_o    = st_reg.out_first;
  assign second_tag_o   = st_reg.out_second;
  assign matched_o      = st_reg.out_hit;
  assign match_index_o  = st_reg.out_index;
  assign read_valid_o   = st_reg.rd_valid;
  assign read_enable_o  = st_reg.rd_enable;
  assign read_key_o     = st_reg.rd_key;
  assign read_mask_o    = st_reg.rd_mask;
  assign read_action_o  = st_reg.rd_action;

endmodule

// *** test/egress_tag_rule_lookup_properties.sv ***
// Purpose: port-level checks for the egress tag lookup stage
// Assumes: single core clock domain, async active-low reset
// Notes:   only relations visible at the top ports; table contents are checked by the bench

`timescale 1ns/10ps

module egress_tag_rule_lookup_checker
  import egress_tag_pkg::*;
(
  input wire logic                   mclk_i,
  input wire logic                   rstn_i,
  input wire logic                   req_valid_i,
  input egress_tag_pkg::frame_ctx_t  req_ctx_i,
  input wire logic                   entry_read_i,
  input wire logic                   result_valid_o,
  input egress_tag_pkg::outer_ctl_t  outer_ctl_o,
  input egress_tag_pkg::tag_out_t    first_tag_o,
  input egress_tag_pkg::tag_out_t    second_tag_o,
  input wire logic                   matched_o,
  input wire logic [7:0]             match_index_o,
  input wire logic                   read_valid_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  lat_exact_a: assert property (req_valid_i |-> ##3 result_valid_o)
    else $error("result missing three cycles after request");
  no_orphan_a: assert property (result_valid_o |-> $past(req_valid_i, 3))
    else $error("result without a request");
  first_push_a: assert property (result_valid_o |->
    (first_tag_o.push == (outer_ctl_o == OUTER_FIRST_TAG))) else $error("outer push mismatch");
  first_tpid_a: assert property (result_valid_o |-> (first_tag_o.tpid == TPID_CTAG) ||
    (first_tag_o.tpid == TPID_STAG) || (first_tag_o.tpid == $past(req_ctx_i.port_custom_ethertype, 3)))
    else $error("outer ethertype out of set");
  second_tpid_a: assert property (result_valid_o |-> (second_tag_o.tpid == TPID_CTAG) ||
    (second_tag_o.tpid == TPID_STAG) || (second_tag_o.tpid == $past(req_ctx_i.port_custom_ethertype, 3)))
    else $error("inner ethertype out of set");
  miss_index_a: assert property (result_valid_o && !matched_o |-> match_index_o == 8'h00)
    else $error("index not zero on default action");
  result_hold_a: assert property (!result_valid_o |->
    $stable(outer_ctl_o) && $stable(first_tag_o) && $stable(matched_o))
    else $error("result changed without a result pulse");
  read_pulse_a: assert property (entry_read_i |=> read_valid_o)
    else $error("readback pulse missing");
  read_cause_a: assert property (read_valid_o |-> $past(entry_read_i))
    else $error("readback pulse without request");
endmodule

bind egress_tag_rule_lookup egress_tag_rule_lookup_checker chk (.mclk_i, .rstn_i, .req_valid_i,
  .req_ctx_i, .entry_read_i, .result_valid_o, .outer_ctl_o, .first_tag_o, .second_tag_o,
  .matched_o, .match_index_o, .read_valid_o);

// *** test/egress_rewriter_model.sv ***
// Purpose: downstream rewriter stand-in, counts lookup results it receives
// Assumes: results are single-cycle pulses on the core clock
// Notes:   no back-pressure, like the real rewriter

`timescale 1ns/10ps

module egress_rewriter_model (
  input  wire logic        mclk_i,
  input  wire logic        rstn_i,
  input  wire logic        result_valid_i,
  output logic [15:0]      result_count_o
);
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) result_count_o <= 16'h0000;
    else if (result_valid_i) result_count_o <= result_count_o + 16'h0001;
  end
endmodule

// *** test/egress_tag_rule_lookup_bench.sv ***
// Purpose: self-checking bench for the egress tag lookup stage
// Assumes: results return in request order, three clocks after the request
// Notes:   eight entries programmed, one disabled; the bench keeps its own table copy

`timescale 1ns/10ps

module egress_tag_rule_lookup_bench;
  import egress_tag_pkg::*;
  typedef struct packed {outer_ctl_t o; tag_out_t a; tag_out_t b; logic m; logic [7:0] i;} exp_t;
  localparam logic [7:0] IDX [8] = '{8'h01, 8'h02, 8'h04, 8'h05, 8'h07, 8'h09, 8'hC8, 8'hFF};
  logic        mclk_i, rstn_i, req_valid_i, entry_write_i, entry_enable_i, default_write_i;
  logic        hit_clear_i, entry_read_i, result_valid_o, matched_o, read_valid_o, read_enable_o;
  logic [3:0]  transmit_port_number_i, receive_port_number_i, default_port_i;
  logic [47:0] dest_mac_i;
  logic [7:0]  entry_index_i, hit_clear_index_i, read_index_i, match_index_o;
  logic [15:0] result_count;
  frame_ctx_t  req_ctx_i;
  lookup_key_t entry_key_i, entry_mask_i, read_key_o, read_mask_o;
  action_t     entry_action_i, default_action_i, read_action_o;
  outer_ctl_t  outer_ctl_o;
  tag_out_t    first_tag_o, second_tag_o;
  logic [27:0] ek [8];
  logic [27:0] em [8];
  action_t     ea [8];
  action_t     da [12];
  logic        hit_seen [8];
  exp_t        q [$];
  int          fail_count, tests_run, n_req;

  egress_tag_rule_lookup uut (.mclk_i, .rstn_i, .req_valid_i, .transmit_port_number_i,
    .receive_port_number_i, .dest_mac_i, .req_ctx_i, .result_valid_o, .outer_ctl_o, .first_tag_o,
    .second_tag_o, .matched_o, .match_index_o, .entry_write_i, .entry_index_i, .entry_enable_i,
    .entry_key_i, .entry_mask_i, .entry_action_i, .default_write_i, .default_port_i,
    .default_action_i, .hit_clear_i, .hit_clear_index_i, .entry_read_i, .read_index_i,
    .read_valid_o, .read_enable_o, .read_key_o, .read_mask_o, .read_action_o);
  egress_rewriter_model partner (.mclk_i, .rstn_i, .result_valid_i(result_valid_o),
    .result_count_o(result_count));

  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [130:0] seen, input logic [130:0] exp);
    tests_run++;
    if (seen !== exp) begin
      $display("ERROR %0t: mismatch seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [27:0] key_f(logic [3:0] tx, logic [3:0] rx, logic [47:0] mac,
                                        frame_ctx_t c);
    lookup_key_t k;
    k = KEY_RESET;
    k.transmit_port_number = tx;
    k.receive_port_number = rx;
    k.dest_multicast_flag = mac[MCAST_BIT];
    k.dest_broadcast_flag = (mac == BCAST_ADDR);
    k.vid = c.vid;
    k.drop_precedence = c.drop_precedence;
    k.pcp = c.pcp;
    return k;
  endfunction

  // same resolution for both tags, so one function serves outer and inner
  function automatic tag_out_t tag_f(logic p, tag_select_t s, logic [11:0] v, logic [2:0] pc,
                                     logic e, frame_ctx_t c);
    tag_out_t t;
    t.push = p;
    case (s.ethertype_select)
      ETYPE_CTAG:   t.tpid = TPID_CTAG;
      ETYPE_STAG:   t.tpid = TPID_STAG;
      ETYPE_CUSTOM: t.tpid = c.port_custom_ethertype;
      default:      t.tpid = c.internal_header_tag_kind ? c.port_custom_ethertype : TPID_CTAG;
    endcase
    t.vid = s.vlan_select ? v : c.vid + v;
    case (s.priority_select)
      PRI_CLASSIFIED: t.pcp = c.pcp;
      PRI_VALUE:      t.pcp = pc;
      PRI_MAPPED:     t.pcp = c.mapped_pcp;
      default:        t.pcp = c.qos_class;
    endcase
    case (s.eligible_select)
      ELI_CLASSIFIED: t.dei = c.dei;
      ELI_VALUE:      t.dei = e;
      ELI_MAPPED:     t.dei = c.mapped_dei;
      default:        t.dei = c.drop_precedence;
    endcase
    return t;
  endfunction

  task automatic new_req(output logic [3:0] tx, output logic [3:0] rx, output logic [47:0] mac,
                         output frame_ctx_t c);
    logic [63:0] r;
    r = {$urandom(), $urandom()};
    tx = 4'($urandom_range(11));
    rx = 4'($urandom_range(11));
    mac = r[47:0] & ~(48'h1 << MCAST_BIT);
    if ($urandom_range(2) == 0) mac = BCAST_ADDR;
    else if ($urandom_range(1) == 0) mac[MCAST_BIT] = 1'b1;
    r = {$urandom(), $urandom()};
    c = r[40:0];
    c.vid = 12'($urandom_range(3));
  endtask

  function automatic action_t rand_act();
    action_t a;
    a = 74'({$urandom(), $urandom(), $urandom()});
    a.reserved = '0;
    a.hit = 1'b0;
    return a;
  endfunction

  task automatic lookup();
    logic [3:0] tx, rx;
    logic [47:0] mac;
    frame_ctx_t c;
    logic [27:0] k;
    exp_t e;
    action_t a;
    int j;
    new_req(tx, rx, mac, c);
    k = key_f(tx, rx, mac, c);
    j = -1;
    for (int i = 7; i >= 0; i--) if (i != 7 && (k & em[i]) == (ek[i] & em[i])) j = i;
    a = (j >= 0) ? ea[j] : da[tx];
    if (j >= 0) hit_seen[j] = 1'b1;
    e.o = a.push_outer;
    e.a = tag_f(a.push_outer == OUTER_FIRST_TAG, a.first_sel, a.first_tag_vlan_value,
                a.first_tag_priority_value, a.first_tag_eligible_value, c);
    e.b = tag_f(a.push_inner, a.second_sel, a.second_tag_vlan_value,
                a.second_tag_priority_value, a.second_tag_eligible_value, c);
    e.m = (j >= 0);
    e.i = (j >= 0) ? IDX[j] : 8'h00;
    q.push_back(e);
    n_req++;
    @(posedge mclk_i);
    req_valid_i <= 1'b1;
    transmit_port_number_i <= tx;
    receive_port_number_i <= rx;
    dest_mac_i <= mac;
    req_ctx_i <= c;
  endtask

  task automatic rd(input int j, input logic full);
    action_t a;
    @(posedge mclk_i);
    entry_read_i <= 1'b1;
    read_index_i <= IDX[j];
    @(posedge mclk_i);
    entry_read_i <= 1'b0;
    #1;
    a = ea[j];
    a.hit = hit_seen[j];
    check(read_valid_o, 1'b1);
    check(read_action_o.hit, hit_seen[j]);
    if (full) check({read_enable_o, read_mask_o, read_key_o & read_mask_o, read_action_o},
                    {j != 7, em[j], ek[j] & em[j], a});
  endtask

  always @(posedge mclk_i) begin
    if (result_valid_o === 1'b1) begin
      if (q.size() == 0) check(1'b1, 1'b0);
      else check({outer_ctl_o, first_tag_o, second_tag_o, matched_o, match_index_o},
                 q.pop_front());
    end
  end

  initial begin
    repeat (5000) @(posedge mclk_i);
    fail_count++;
    wrap_up();
  end

  initial begin
    logic [3:0] tx, rx;
    logic [47:0] mac;
    frame_ctx_t c;
    void'($urandom(83));
    {rstn_i, req_valid_i, entry_write_i, entry_enable_i, default_write_i, hit_clear_i} = '0;
    {entry_read_i, transmit_port_number_i, receive_port_number_i, default_port_i} = '0;
    {dest_mac_i, entry_index_i, hit_clear_index_i, read_index_i, req_ctx_i} = '0;
    {entry_key_i, entry_mask_i, entry_action_i, default_action_i} = '0;
    fail_count = 0;
    tests_run = 0;
    n_req = 0;
    repeat (16) @(posedge mclk_i);
    rstn_i <= 1'b1;
    for (int i = 0; i < 8; i++) hit_seen[i] = 1'b0;
    rd(0, 1'b0); // sticky bits start cleared
    for (int i = 0; i < 12; i++) begin
      da[i] = rand_act();
      @(posedge mclk_i);
      {default_write_i, default_port_i, default_action_i} <= {1'b1, 4'(i), da[i]};
    end
    for (int i = 0; i < 8; i++) begin
      new_req(tx, rx, mac, c);
      ek[i] = key_f(tx, rx, mac, c);
      em[i] = '0;
      // entries 1 to 5 match one field, 0 pcp plus drop precedence, 6 every field; reserved bits stay don't care
      case (i)
        0: em[i] = 28'hF000000;
        1: begin em[i] = 28'h0000800; ek[i][11] = 1'b1; end
        2: em[i] = 28'h00000F0;
        3: em[i] = 28'h000000F;
        4: em[i] = 28'h0FFF000;
        5: begin em[i] = 28'h0000400; ek[i][10] = 1'b1; end
        6: em[i] = 28'hFFFFCFF;
        default: em[i] = 28'h0000000;
      endcase
      ea[i] = rand_act();
      @(posedge mclk_i);
      {entry_write_i, entry_index_i, entry_enable_i} <= {1'b1, IDX[i], i != 7};
      {entry_key_i, entry_mask_i, entry_action_i} <= {ek[i], em[i], ea[i]};
    end
    @(posedge mclk_i);
    {entry_write_i, default_write_i} <= 2'b00;
    repeat (600) lookup();
    @(posedge mclk_i);
    req_valid_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    check(q.size(), 0);
    check(result_count, n_req);
    for (int i = 0; i < 8; i++) rd(i, 1'b1);
    @(posedge mclk_i);
    {hit_clear_i, hit_clear_index_i} <= {1'b1, IDX[3]};
    @(posedge mclk_i);
    hit_clear_i <= 1'b0;
    hit_seen[3] = 1'b0;
    rd(3, 1'b1);
    wrap_up();
  end
endmodule
